// *** icc_pkg.sv ***
// icc_pkg: constants shared by the isa cycle controller, its fifo and its synchroniser.
// assumes a 10 MHz core clock and an isa reference clock sampled as a plain input.
package icc_pkg;
    // command word layout, pushed into the request fifo
    localparam int CMD_W = 44;
    localparam int DATA_LSB = 0;
    localparam int DATA_W = 16;
    localparam int ADDR_LSB = 16;
    localparam int ADDR_W = 24;
    localparam int WIDE_BIT = 40;
    localparam int WR_BIT = 41;
    localparam int KIND_LSB = 42;
    localparam int KIND_W = 2;
    localparam int FIFO_DEPTH = 4;
    // cycle kinds
    localparam logic [1:0] KIND_IO = 2'h0;
    localparam logic [1:0] KIND_DMA = 2'h1;
    localparam logic [1:0] KIND_REF = 2'h2;
    // reset values of the isa pins
    localparam logic AEN_RST = 1'b0;
    localparam logic BALE_RST = 1'b0;
    localparam logic STROBE_RST = 1'b1;
    localparam logic RDY_OE_RST = 1'b0;
    // cycle phases, counted in isa clock rising edges
    localparam logic [2:0] ADDR_CLKS = 3'h1;
    localparam logic [2:0] CMD_CLKS = 3'h2;
    localparam logic [2:0] REC_CLKS = 3'h1;
    // synchronised input bundle: {iochk_n, iocs16_n, iochrdy, master, refclk}
    localparam int SYNC_W = 5;
    localparam logic [4:0] SYNC_RST = 5'h1c;
endpackage : icc_pkg

// *** icc_sync.sv ***
// icc_sync: two flop synchroniser for a bundle of pin levels.
// assumes each bit is a slow level; multi-bit words are only read while stable.
`timescale 1ns/1ps
module icc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : icc_sync

// *** icc_fifo.sv ***
// icc_fifo: small request fifo with valid/ready on both sides.
// assumes one clock; the reader may stall so the fifo really fills.
`timescale 1ns/1ps
module icc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr];
    assign outValid = (count != '0);

    // occupancy follows pushes and pops
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // pointers, count and a registered ready
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            inReady <= 1'b1;
        end else begin
            if (push) begin
                wrPtr <= AW'(wrPtr + 1'b1);
            end
            if (pop) begin
                rdPtr <= AW'(rdPtr + 1'b1);
            end
            count <= next_count;
            inReady <= (next_count != (AW+1)'(DEPTH));
        end
    end

    // storage written at the write pointer
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule : icc_fifo

// *** icc_isa_cycle_control.sv ***
// icc_isa_cycle_control: runs isa i/o, dma and refresh cycles from queued commands.
// assumes an isa reference clock on a pin and slaves on the far side of the isa bus.
// Operation
// - aen high through every dma cycle
// - aen high through every refresh cycle
// - aen low during reset
// - bale marks valid address, aen and byte-high enable
// - bale held high in dma and external master cycles
// - bale low during reset
// - isa clock output follows the 6 to 8.33 MHz reference
// - slave stretches cycle via iochrdy; master inserts wait states
// - iochrdy left undriven during reset
// - iochk raises nmi only when nmi enabled
// - read strobe lets slave drive data bus
// - write strobe lets slave latch data bus
// - read strobe high during reset
// - write strobe high during reset
// - address driven only while this side owns the bus
// - byte-high enable negated in refresh cycles
`timescale 1ns/1ps
module icc_isa_cycle_control (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [icc_pkg::CMD_W-1:0] cmdWord,
    output logic rspValid,
    output logic [icc_pkg::DATA_W-1:0] rspData,
    output logic rspWide,
    output logic busy,
    input wire logic extMasterOwn,
    input wire logic nmiEnable,
    output logic nmi,
    input wire logic isaClkRef,
    output logic sysClk,
    output logic aen,
    output logic bale,
    output logic [6:0] laOut,
    output logic laOe,
    output logic [19:0] saOut,
    output logic saOe,
    input wire logic [19:0] saIn,
    output logic sbheNOut,
    output logic sbheNOe,
    output logic [15:0] sdOut,
    output logic sdOe,
    input wire logic [15:0] sdIn,
    output logic iorNOut,
    output logic iorNOe,
    input wire logic iorNIn,
    output logic iowNOut,
    output logic iowNOe,
    input wire logic iowNIn,
    output logic iochrdyOut,
    output logic iochrdyOe,
    input wire logic iochrdyIn,
    input wire logic iocs16N,
    input wire logic iochkN
);
    import icc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_REC
    } icc_state_e;

    icc_state_e state;
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] syncOut;
    logic [15:0] sdSync;
    logic refPrev;
    logic isaRise;
    logic masterOwn;
    logic rdyNow;
    logic cs16Now;
    logic chkNow;
    logic fifoValid;
    logic fifoPop;
    logic [CMD_W-1:0] fifoWord;
    logic [CMD_W-1:0] cur;
    logic [2:0] phaseCnt;
    logic hiPhase;
    logic cs16Samp;
    logic [15:0] rdBuf;

    // kind of the current command
    function automatic logic [1:0] kindOf(input logic [CMD_W-1:0] w);
        kindOf = w[KIND_LSB +: KIND_W];
    endfunction : kindOf

    // a wide i/o cycle that the slave did not accept as 16 bit needs a second byte
    function automatic logic needsSplit(input logic [CMD_W-1:0] w, input logic cs16);
        needsSplit = w[WIDE_BIT] && !cs16 && (kindOf(w) == KIND_IO);
    endfunction : needsSplit

    // pins from outside the core domain pass two flops
    assign syncIn = {iochkN, iocs16N, iochrdyIn, extMasterOwn, isaClkRef};

    icc_sync #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync_ctl (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(syncIn),
        .dout(syncOut)
    );

    icc_sync #(
        .W(16),
        .RST_VAL(16'h0000)
    ) u_sync_data (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(sdIn),
        .dout(sdSync)
    );

    // synchronised levels
    assign chkNow = !syncOut[4];
    assign cs16Now = !syncOut[3];
    assign rdyNow = syncOut[2];
    assign masterOwn = syncOut[1];
    assign isaRise = syncOut[0] && !refPrev;

    icc_fifo #(
        .W(CMD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .inValid(cmdValid),
        .inReady(cmdReady),
        .inData(cmdWord),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoWord)
    );

    // take a command only on an isa edge while this side owns the bus
    assign fifoPop = (state == ST_IDLE) && isaRise && fifoValid && !masterOwn;

    // isa clock regenerated from the sampled reference, edge history
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            refPrev <= 1'b0;
            sysClk <= 1'b0;
        end else begin
            refPrev <= syncOut[0];
            sysClk <= syncOut[0];
        end
    end

    // nmi from channel check, gated by the enable
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            nmi <= 1'b0;
        end else begin
            nmi <= chkNow && nmiEnable;
        end
    end

    // iochrdy is only ever sensed, never driven
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            iochrdyOe <= RDY_OE_RST;
            iochrdyOut <= 1'b1;
        end else begin
            iochrdyOe <= RDY_OE_RST;
            iochrdyOut <= 1'b1;
        end
    end

    // cycle sequencer, advancing on isa clock rising edges
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cur <= '0;
            phaseCnt <= 3'h0;
            hiPhase <= 1'b0;
            cs16Samp <= 1'b0;
            rdBuf <= 16'h0000;
        end else if (isaRise) begin
            case (state)
                ST_IDLE: begin
                    if (fifoPop) begin
                        cur <= fifoWord;
                        hiPhase <= 1'b0;
                        phaseCnt <= ADDR_CLKS;
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    cs16Samp <= cs16Now;
                    if (phaseCnt > 3'h1) begin
                        phaseCnt <= phaseCnt - 3'h1;
                    end else begin
                        phaseCnt <= CMD_CLKS;
                        state <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (phaseCnt > 3'h1) begin
                        phaseCnt <= phaseCnt - 3'h1;
                    end else if (rdyNow) begin
                        if (hiPhase) begin
                            rdBuf[15:8] <= sdSync[7:0];
                        end else if (cur[WIDE_BIT] && cs16Samp) begin
                            rdBuf <= sdSync;
                        end else begin
                            rdBuf <= {8'h00, sdSync[7:0]};
                        end
                        phaseCnt <= REC_CLKS;
                        state <= ST_REC;
                    end
                end
                ST_REC: begin
                    if (phaseCnt > 3'h1) begin
                        phaseCnt <= phaseCnt - 3'h1;
                    end else if (!hiPhase && needsSplit(cur, cs16Samp)) begin
                        hiPhase <= 1'b1;
                        cur[ADDR_LSB +: ADDR_W] <= cur[ADDR_LSB +: ADDR_W] + 24'h000001;
                        phaseCnt <= ADDR_CLKS;
                        state <= ST_ADDR;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // completion reported on the same core edge that the sequencer returns to idle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rspValid <= 1'b0;
            rspData <= 16'h0000;
            rspWide <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            if (isaRise && state == ST_REC && phaseCnt <= 3'h1
                && !(!hiPhase && needsSplit(cur, cs16Samp))) begin
                rspValid <= 1'b1;
                rspData <= rdBuf;
                rspWide <= cur[WIDE_BIT] && cs16Samp;
            end
        end
    end

    // address enable and latch enable
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aen <= AEN_RST;
            bale <= BALE_RST;
        end else begin
            aen <= (state != ST_IDLE) && (kindOf(cur) != KIND_IO);
            if (masterOwn && state == ST_IDLE) begin
                bale <= 1'b1;
            end else if (state == ST_ADDR) begin
                bale <= 1'b1;
            end else if (state != ST_IDLE && kindOf(cur) == KIND_DMA) begin
                bale <= 1'b1;
            end else begin
                bale <= 1'b0; // falling edge latches upper address
            end
        end
    end

    // address, byte-high enable and their drivers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            saOut <= 20'h00000;
            saOe <= 1'b0;
            laOut <= 7'h00;
            laOe <= 1'b0;
            sbheNOut <= 1'b1;
            sbheNOe <= 1'b0;
        end else begin
            saOut <= cur[ADDR_LSB +: 20];
            laOut <= cur[ADDR_LSB + 17 +: 7];
            saOe <= (state != ST_IDLE) && !masterOwn;
            laOe <= (state != ST_IDLE) && !masterOwn;
            sbheNOe <= (state != ST_IDLE) && !masterOwn;
            if (kindOf(cur) == KIND_REF) begin
                sbheNOut <= 1'b1;
            end else begin
                sbheNOut <= !(cur[WIDE_BIT] && !hiPhase);
            end
        end
    end

    // command strobes and write data
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            iorNOut <= STROBE_RST;
            iowNOut <= STROBE_RST;
            iorNOe <= 1'b0;
            iowNOe <= 1'b0;
            sdOut <= 16'h0000;
            sdOe <= 1'b0;
        end else begin
            iorNOe <= (state != ST_IDLE) && !masterOwn;
            iowNOe <= (state != ST_IDLE) && !masterOwn;
            iorNOut <= !(state == ST_CMD && !cur[WR_BIT] && kindOf(cur) != KIND_REF);
            iowNOut <= !(state == ST_CMD && cur[WR_BIT] && kindOf(cur) != KIND_REF);
            sdOe <= (state == ST_CMD || state == ST_ADDR) && cur[WR_BIT] && kindOf(cur) != KIND_REF;
            if (hiPhase) begin
                sdOut <= {8'h00, cur[DATA_LSB + 8 +: 8]};
            end else begin
                sdOut <= cur[DATA_LSB +: DATA_W]; // whole word driven in the first phase, whatever iocs16 says
            end
        end
    end

    // busy while a cycle is in flight
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != ST_IDLE);
        end
    end
endmodule : icc_isa_cycle_control

// *** icc_isa_cycle_control_assertions.sv ***
// icc_isa_cycle_control_chk: concurrent checks on the isa pins of the cycle controller.
// assumes one core clock domain; pins are watched at the top module's ports.
`timescale 1ns/1ps
module icc_isa_cycle_control_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic nmiEnable,
    input wire logic nmi,
    input wire logic isaClkRef,
    input wire logic sysClk,
    input wire logic aen,
    input wire logic bale,
    input wire logic laOe,
    input wire logic saOe,
    input wire logic sbheNOut,
    input wire logic iorNOut,
    input wire logic iowNOut,
    input wire logic iochrdyOe,
    input wire logic iochkN
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // pin levels at the first edge after reset still show the reset values
    a_aen_reset_low: assert property ($rose(nrst) |-> !aen)
        else $error("aen high after reset");
    a_bale_reset_low: assert property ($rose(nrst) |-> !bale)
        else $error("bale high after reset");
    a_strobe_reset_high: assert property ($rose(nrst) |-> iorNOut && iowNOut)
        else $error("strobe low after reset");
    a_rdy_not_driven: assert property (!iochrdyOe)
        else $error("iochrdy driven");
    // a strobe with bale still high only happens in dma, which keeps aen up
    a_dma_aen_high: assert property ((!iorNOut || !iowNOut) && bale |-> aen)
        else $error("dma without aen");
    a_dma_bale_held: assert property (aen && !iorNOut ##1 aen |-> bale)
        else $error("bale dropped in dma");
    a_refresh_sbhe_neg: assert property (aen && !bale |-> sbheNOut)
        else $error("sbhe low in refresh");
    a_nmi_gated: assert property ((nmiEnable && !iochkN)[*4] |-> nmi)
        else $error("nmi missing");
    a_nmi_masked: assert property (!nmiEnable[*2] |-> !nmi)
        else $error("nmi while disabled");
    a_sysclk_follows: assert property ($stable(isaClkRef)[*3] |-> sysClk == isaClkRef)
        else $error("sysclk off reference");
    a_addr_at_bale: assert property ($fell(bale) && (!iorNOut || !iowNOut) |-> saOe && laOe)
        else $error("address not driven");
endmodule : icc_isa_cycle_control_chk

bind icc_isa_cycle_control icc_isa_cycle_control_chk u_icc_isa_cycle_control_chk (.core_clk, .nrst, .nmiEnable,
    .nmi, .isaClkRef, .sysClk, .aen, .bale, .laOe, .saOe, .sbheNOut, .iorNOut, .iowNOut, .iochrdyOe, .iochkN);

// *** icc_isa_slave.sv ***
// icc_isa_slave: behavioural isa i/o slave card with wait states and a 16-bit decode.
// assumes wire levels of the strobes; pull-ups hold iochrdy and iocs16 high when released.
`timescale 1ns/1ps
module icc_isa_slave (
    input wire logic sysClk,
    input wire logic iorNIn,
    input wire logic iowNIn,
    input wire logic bale,
    input wire logic [6:0] laOut,
    input wire logic saOe,
    input wire logic sdOe,
    input wire logic [15:0] sdOut,
    input wire logic cs16,
    input wire logic [3:0] waitClks,
    input wire logic [15:0] rdVal,
    output logic [15:0] sdS,
    output logic rdyS,
    output logic iocs16N,
    output logic [15:0] wrVal,
    output logic [6:0] laQ
);
    logic strbQ = 1'b0;
    logic [3:0] waitCnt = '0;
    logic [15:0] lastSd = '0;
    wire strb = !(iorNIn && iowNIn);
    // wait states counted from the first isa clock of a command; write data latched under the strobe
    always @(posedge sysClk) begin
        strbQ <= strb;
        if (strb && !strbQ) waitCnt <= waitClks;
        else if (waitCnt != 4'h0) waitCnt <= waitCnt - 4'h1;
        if (!iowNIn && sdOe) wrVal <= sdOut;
        if (!iorNIn) lastSd <= rdVal;
    end
    // upper address captured as bale falls
    always @(negedge bale) laQ <= laOut;
    // read data only under the read strobe; otherwise the line shows the inverse of the last value
    assign sdS = !iorNIn ? rdVal : ~lastSd;
    assign rdyS = !(strb && waitCnt != 4'h0);
    assign iocs16N = !(cs16 && saOe);
endmodule : icc_isa_slave

// *** tb_top.sv ***
// tb_top: directed bench for the isa cycle controller with a slave card model.
// assumes a 10 MHz core clock and a free running 800 ns isa reference clock.
`timescale 1ns/1ps
module tb_top;
    import icc_pkg::*;
    logic core_clk = 0, nrst = 0, cmdValid = 0, extMasterOwn = 0, nmiEnable = 0, isaClkRef = 0, iochkN = 1;
    logic cmdReady, rspValid, rspWide, busy, nmi, sysClk, aen, bale, laOe, saOe, sbheNOut, sbheNOe, sdOe;
    logic iorNOut, iorNOe, iowNOut, iowNOe, iochrdyOut, iochrdyOe, rdyS, iocs16N, cs16 = 0;
    logic [CMD_W-1:0] cmdWord = '0;
    logic [15:0] rspData, sdOut, sdS, wrVal, rdVal = '0;
    logic [6:0] laOut, laQ;
    logic [19:0] saOut, saIn = '0;
    logic [3:0] waitClks = '0;
    logic aenAll, baleAll, sbheAll, anyIor, anyIow;
    int fail_count = 0, checks = 0, cyc = 0, len0, len;
    // wire levels seen by every party
    wire logic [15:0] sdIn = sdOe ? sdOut : sdS;
    wire logic iorNIn = iorNOe ? iorNOut : 1'b1;
    wire logic iowNIn = iowNOe ? iowNOut : 1'b1;
    wire logic iochrdyIn = iochrdyOe ? iochrdyOut : rdyS;
    icc_isa_cycle_control u_icc_isa_cycle_control (.core_clk, .nrst, .cmdValid, .cmdReady, .cmdWord,
        .rspValid, .rspData, .rspWide, .busy, .extMasterOwn, .nmiEnable, .nmi, .isaClkRef, .sysClk, .aen,
        .bale, .laOut, .laOe, .saOut, .saOe, .saIn, .sbheNOut, .sbheNOe, .sdOut, .sdOe, .sdIn, .iorNOut,
        .iorNOe, .iorNIn, .iowNOut, .iowNOe, .iowNIn, .iochrdyOut, .iochrdyOe, .iochrdyIn, .iocs16N, .iochkN);
    icc_isa_slave u_icc_isa_slave (.sysClk, .iorNIn, .iowNIn, .bale, .laOut, .saOe, .sdOe, .sdOut, .cs16,
        .waitClks, .rdVal, .sdS, .rdyS, .iocs16N, .wrVal, .laQ);
    // clocks: reference starts at an odd phase to the core clock
    always #50 core_clk = ~core_clk;
    initial begin
        #137;
        forever #400 isaClkRef = ~isaClkRef;
    end
    // a hung run is cut short here
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // offer one command at a falling edge and hold it until the fifo takes it
    task automatic push(input logic [1:0] k, input logic wr, input logic wd, input logic [15:0] d);
        cmdWord = {k, wr, wd, 24'h0a0300, d};
        cmdValid = 1;
        while (!cmdReady) @(negedge core_clk);
        @(negedge core_clk);
    endtask : push
    // wait for the response pulse, recording pin levels while a cycle is in flight
    // always lets one edge pass first, so back-to-back calls never reuse one pulse
    task automatic rsp();
        cmdValid = 0;
        {aenAll, baleAll, sbheAll, anyIor, anyIow} = 5'h1c;
        len = 0;
        do begin
            @(negedge core_clk);
            len++;
            if (busy) begin
                aenAll &= aen;
                baleAll &= bale;
                sbheAll &= sbheNOut;
            end
            anyIor |= !iorNOut;
            anyIow |= !iowNOut;
        end while (!rspValid && len < 600);
        chk(rspValid, 1);
    endtask : rsp
    task automatic t_reset();
        chk(aen, 0);
        chk(bale, 0);
        chk(iochrdyOe, 0);
        chk({iorNOut, iowNOut}, 2'h3);
    endtask : t_reset
    // narrow read, the same with slave waits, wide read and wide write, then both split
    task automatic t_io();
        rdVal = 16'h5aa5;
        push(KIND_IO, 0, 0, 16'h0);
        rsp();
        len0 = len;
        chk(rspData[7:0], 8'ha5);
        chk({rspWide, anyIor, anyIow}, 3'h2);
        chk(laQ, 7'h05);
        waitClks = 4'h4;
        push(KIND_IO, 0, 0, 16'h0);
        rsp();
        chk(len >= len0 + 16, 1);
        waitClks = 4'h0;
        cs16 = 1;
        rdVal = 16'hc33c;
        push(KIND_IO, 0, 1, 16'h0);
        rsp();
        chk({rspWide, rspData}, 17'h1c33c);
        push(KIND_IO, 1, 1, 16'h9e71);
        rsp();
        chk({anyIow, wrVal}, 17'h19e71);
        // an 8-bit slave splits wide cycles: the high byte follows on the low lane
        cs16 = 0;
        push(KIND_IO, 0, 1, 16'h0);
        rsp();
        chk({rspWide, rspData}, 17'h03c3c);
        push(KIND_IO, 1, 1, 16'h9e71);
        rsp();
        chk({anyIow, wrVal[7:0]}, 17'h0019e);
    endtask : t_io
    task automatic t_dma_ref();
        push(KIND_DMA, 0, 0, 16'h0);
        rsp();
        chk({aenAll, baleAll, anyIor}, 3'h7);
        push(KIND_REF, 0, 1, 16'h0); // wide flag set so byte-high enable would drop without the refresh rule
        rsp();
        chk({aenAll, sbheAll, anyIor | anyIow}, 3'h6);
    endtask : t_dma_ref
    // channel check from a card, masked then enabled then withdrawn
    task automatic t_nmi();
        iochkN = 0;
        repeat (6) @(negedge core_clk);
        chk(nmi, 0);
        nmiEnable = 1;
        repeat (6) @(negedge core_clk);
        chk(nmi, 1);
        iochkN = 1;
        repeat (6) @(negedge core_clk);
        chk(nmi, 0);
    endtask : t_nmi
    // outside master holds the bus while the fifo fills, then all four queued reads drain
    task automatic t_ext();
        extMasterOwn = 1;
        repeat (8) @(negedge core_clk);
        chk({bale, saOe}, 2'h2);
        repeat (4) push(KIND_IO, 0, 0, 16'h0);
        cmdValid = 0;
        repeat (20) @(negedge core_clk);
        chk({cmdReady, busy}, 2'h0);
        extMasterOwn = 0;
        repeat (4) rsp();
        chk(cmdReady, 1);
    endtask : t_ext
    task automatic t_clk();
        int n;
        logic p;
        n = 0;
        p = sysClk;
        repeat (80) begin
            @(negedge core_clk);
            n += int'(sysClk && !p);
            p = sysClk;
        end
        chk(n >= 9 && n <= 11, 1);
    endtask : t_clk
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        t_reset();
        nrst = 1;
        @(negedge core_clk);
        t_io();
        t_dma_ref();
        t_nmi();
        t_ext();
        t_clk();
        end_sim();
    end
endmodule : tb_top
